// >>> rtl/flash_program_status_tracking.sv
// partitioned flash command decode, program sequencing and status flags
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"
//
// Contract
// RULE_01: status bit 7 reads 0 while any program or erase runs, 1 when ready.
// RULE_02: bits 6..1 are meaningless while bit 7 is 0; host ignores them.
// RULE_03: erase suspend halts, shows ready and erase-suspended until erase resume.
// RULE_04: failed block erase sets bit 5; successful erase leaves it 0.
// RULE_05: bad command sequence sets ready, erase-fail and program-fail together.
// RULE_06: failed word program sets bit 4.
// RULE_07: voltage-low bit updated only when an operation ends or aborts.
// RULE_08: program suspend halts, shows ready and program-suspended until resume.
// RULE_09: program or erase to locked block with write-protect low aborts, sets bit 1.
// RULE_10: bit 0 with bit 7 tells which partition is busy, or none.
// RULE_11: bits 7 and 0 are never both 1.
// RULE_12: in streaming program mode bit 0 shows the current word pulse state.
// RULE_13: clear-status empties status but leaves read modes untouched.
// RULE_14: machine clears only bits 7,6,2,0; error bits clear only by clear-status.
// RULE_15: device reset low clears the whole status register.
// RULE_16: host clears status after any error before a new command.
// RULE_17: program only turns ones to zeros; ones in data leave cells alone.
// RULE_18: one partition programs at a time; one erase suspended at most.
// RULE_19: status read from any partition carries device busy in bit 7.
// RULE_20: busy partition accepts status, suspend, identifier, query and array reads; while streaming the code takes no command at all.
// RULE_21: each chip or output enable toggle refreshes status; mode stays.
// RULE_22: standby is held off until a running program completes.
// RULE_23: status is 8 bits on data 7..0, upper data lines read zero.
// RULE_24: each partition keeps its own bits 6..0; bit 7 is shared.
// RULE_25: after program, erase or streaming setup the partition reads status; the code switches it only on the following confirm or data write.
// RULE_26: host starts a word program with either setup code then data.
// RULE_27: pulse length is a parameter; busy held throughout, released together.
module flash_program_status_tracking #(
    parameter int unsigned PROG_CYCLES = `PROG_CYCLES,
    parameter logic [15:0] MFR_CODE = 16'h00a5,  // arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h5a01   // arbitrary value
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rst_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [`WORD_W-1:0] dq_in,
    output logic [`WORD_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic wp_n,
    input wire logic vpp_low,
    input wire logic [`NUM_PART-1:0] locked_blocks,
    input wire logic program_fault,
    input wire logic erase_fault,
    output logic standby
);
    import flash_pkg::*;

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    array_if arr ();
    logic dev_rst;
    logic we_n_ff, oe_n_ff, ce_n_ff;
    logic wr_take, wr_cmd, wr_idle_cmd, rd_latch;
    logic [7:0] cmd;
    logic [`PART_W-1:0] wr_part;
    seq_t seq_ff;
    op_t op_ff;
    logic [`PART_W-1:0] op_part_ff;
    logic [`ADDR_W-1:0] op_addr_ff;
    logic [`WORD_W-1:0] op_data_ff;
    logic [31:0] cnt_ff;
    logic busy, streaming, pulsing, last_pulse;
    logic start_prog, start_erase, start_stream, start_any, seq_error;
    logic lock_abort, vpp_abort, launch_ok;
    logic suspend_req, resume_req, ev_pfin, ev_efin;
    logic [`SR_ESUSP:`SR_LOCK] part_sts_ff [`NUM_PART];
    read_mode_t mode_ff [`NUM_PART];

    flash_array u_array (
        .clk(clk),
        .sys_rst(sys_rst),
        .mem(arr.mem)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [`PART_W-1:0] part_of(input logic [`ADDR_W-1:0] a);
        part_of = a[`ADDR_W-1:`OFS_W];
    endfunction

    // one status byte as seen from partition p
    function automatic logic [7:0] status_byte(input logic [`PART_W-1:0] p);
        logic [7:0] s;
        s = '0;
        s[`SR_BUSY] = !busy;                                 // [RULE_01] [RULE_19]
        s[`SR_ESUSP:`SR_LOCK] = part_sts_ff[p];              // [RULE_24] [RULE_02]
        if (streaming) begin
            s[`SR_PART] = pulsing;                           // [RULE_12]
        end else begin
            s[`SR_PART] = busy && (p != op_part_ff);         // [RULE_10] [RULE_11]
        end
        status_byte = s;
    endfunction

    // ---------------------------------------------------------------
    // bus edge detection
    // ---------------------------------------------------------------
    // the device reset pin acts like the system reset, both synchronous
    assign dev_rst = sys_rst || !rst_n;                      // [RULE_15]

    always_ff @(posedge clk) begin
        if (dev_rst) begin
            we_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            ce_n_ff <= 1'b1;
        end else begin
            we_n_ff <= we_n;
            oe_n_ff <= oe_n;
            ce_n_ff <= ce_n;
        end
    end

    // writes are taken on the rising edge of write enable
    assign wr_take = !ce_n && we_n && !we_n_ff;
    assign rd_latch = !ce_n && !oe_n && we_n && (oe_n_ff || ce_n_ff);  // [RULE_21]
    assign cmd = dq_in[7:0];
    assign wr_part = part_of(addr);
    // in streaming mode every write is data, never a command
    assign wr_cmd = wr_take && !streaming;
    assign wr_idle_cmd = wr_cmd && (seq_ff == SEQ_IDLE);

    // ---------------------------------------------------------------
    // operation events
    // ---------------------------------------------------------------
    assign streaming = (op_ff == OP_STREAM_WAIT) || (op_ff == OP_STREAM_PULSE);
    assign pulsing = (op_ff == OP_PROG) || (op_ff == OP_STREAM_PULSE);
    assign busy = pulsing || streaming || (op_ff == OP_ERASE);  // [RULE_27]
    assign last_pulse = cnt_ff == PROG_CYCLES - 1;

    assign start_prog = wr_cmd && (seq_ff == SEQ_PROG);        // [RULE_26]
    assign start_erase = wr_cmd && (seq_ff == SEQ_ERASE) && (cmd == `CMD_CONFIRM);
    assign start_stream = wr_cmd && (seq_ff == SEQ_STREAM) && (cmd == `CMD_CONFIRM);
    assign start_any = start_prog || start_erase || start_stream;
    // a two-cycle sequence broken by anything but confirm
    assign seq_error = wr_cmd && ((seq_ff == SEQ_ERASE) || (seq_ff == SEQ_STREAM))
                       && (cmd != `CMD_CONFIRM);               // [RULE_05]

    assign lock_abort = start_any && locked_blocks[wr_part] && !wp_n;  // [RULE_09]
    assign vpp_abort = start_any && vpp_low;                 // [RULE_07]
    assign launch_ok = !lock_abort && !vpp_abort;

    // suspend applies to the running program or erase from any partition
    assign suspend_req = wr_idle_cmd && (cmd == `CMD_SUSPEND)
                         && ((op_ff == OP_PROG) || (op_ff == OP_ERASE));
    assign resume_req = wr_idle_cmd && (cmd == `CMD_CONFIRM)
                        && ((op_ff == OP_PSUSP) || (op_ff == OP_ESUSP));
    assign ev_pfin = pulsing && last_pulse && !suspend_req;
    assign ev_efin = (op_ff == OP_ERASE) && (op_addr_ff[`OFS_W-1:0] == `LAST_OFS)
                     && !suspend_req;

    // ---------------------------------------------------------------
    // setup sequence tracking
    // ---------------------------------------------------------------
    // setup codes are ignored while anything is running or suspended
    always_ff @(posedge clk) begin
        if (dev_rst) begin
            seq_ff <= SEQ_IDLE;
        end else if (wr_cmd) begin
            seq_ff <= SEQ_IDLE;
            if (seq_ff == SEQ_IDLE && op_ff == OP_IDLE) begin   // [RULE_18] [RULE_20]
                unique case (cmd)
                    `CMD_PROG_SETUP, `CMD_PROG_SETUP_ALT: seq_ff <= SEQ_PROG;  // [RULE_26]
                    `CMD_ERASE_SETUP: seq_ff <= SEQ_ERASE;
                    `CMD_STREAM_SETUP: seq_ff <= SEQ_STREAM;
                    default: seq_ff <= SEQ_IDLE;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // write state machine
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (dev_rst) begin
            op_ff <= OP_IDLE;
            op_part_ff <= '0;
            op_addr_ff <= '0;
            op_data_ff <= '0;
            cnt_ff <= '0;
        end else begin
            unique case (op_ff)
                OP_IDLE: begin
                    cnt_ff <= '0;
                    op_part_ff <= wr_part;
                    op_data_ff <= dq_in;
                    if (start_prog && launch_ok) begin
                        op_ff <= OP_PROG;
                        op_addr_ff <= addr;
                    end else if (start_erase && launch_ok) begin
                        op_ff <= OP_ERASE;
                        op_addr_ff <= {wr_part, {`OFS_W{1'b0}}};
                    end else if (start_stream && launch_ok) begin
                        op_ff <= OP_STREAM_WAIT;
                        op_addr_ff <= addr;
                    end
                end
                OP_PROG: begin
                    if (suspend_req) begin
                        op_ff <= OP_PSUSP;                   // [RULE_08]
                    end else if (last_pulse) begin
                        op_ff <= OP_IDLE;                    // [RULE_27]
                    end else begin
                        cnt_ff <= cnt_ff + 32'd1;
                    end
                end
                OP_ERASE: begin
                    if (suspend_req) begin
                        op_ff <= OP_ESUSP;                   // [RULE_03]
                    end else if (ev_efin) begin
                        op_ff <= OP_IDLE;
                    end else begin
                        op_addr_ff <= op_addr_ff + 1'b1;
                    end
                end
                OP_STREAM_WAIT: begin
                    cnt_ff <= '0;
                    if (wr_take) begin
                        // all-ones to another block ends the stream
                        if (part_of(addr) != op_part_ff && dq_in == `ERASED_WORD) begin
                            op_ff <= OP_IDLE;
                        end else begin
                            op_ff <= OP_STREAM_PULSE;
                            op_data_ff <= dq_in;
                        end
                    end
                end
                OP_STREAM_PULSE: begin
                    if (last_pulse) begin
                        op_ff <= OP_STREAM_WAIT;
                        op_addr_ff[`OFS_W-1:0] <= op_addr_ff[`OFS_W-1:0] + 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff + 32'd1;
                    end
                end
                OP_PSUSP: begin
                    if (resume_req) begin
                        op_ff <= OP_PROG;                    // [RULE_08]
                    end
                end
                OP_ESUSP: begin
                    if (resume_req) begin
                        op_ff <= OP_ERASE;                   // [RULE_03]
                    end
                end
                default: op_ff <= OP_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // cell array access
    // ---------------------------------------------------------------
    // old contents are read during the pulse so that only ones turn to zeros
    assign arr.rd_addr = pulsing ? op_addr_ff : addr;
    assign arr.wr_addr = op_addr_ff;
    assign arr.wr_en = (ev_pfin && !program_fault) || (op_ff == OP_ERASE && !suspend_req
                       && !erase_fault);
    assign arr.wr_data = (op_ff == OP_ERASE) ? `ERASED_WORD
                         : (arr.rd_data & op_data_ff);       // [RULE_17]

    // ---------------------------------------------------------------
    // per-partition status flags
    // ---------------------------------------------------------------
    // clear is applied first so that a same-cycle hardware set wins
    generate
        for (genvar p = 0; p < `NUM_PART; p++) begin : g_sts
            logic here_wr, here_op;
            assign here_wr = wr_part == p;
            assign here_op = op_part_ff == p;
            always_ff @(posedge clk) begin
                if (dev_rst) begin
                    part_sts_ff[p] <= `SR_CLEAR;             // [RULE_15]
                end else begin
                    if (wr_idle_cmd && cmd == `CMD_CLEAR_STATUS && here_wr) begin
                        part_sts_ff[p] <= `SR_CLEAR;         // [RULE_13] [RULE_14]
                    end
                    if (seq_error && here_wr) begin
                        part_sts_ff[p][`SR_EFAIL] <= 1'b1;   // [RULE_05]
                        part_sts_ff[p][`SR_PFAIL] <= 1'b1;
                    end
                    if (lock_abort && here_wr) begin
                        part_sts_ff[p][`SR_LOCK] <= 1'b1;    // [RULE_09]
                    end
                    if (vpp_abort && here_wr) begin
                        part_sts_ff[p][`SR_VLOW] <= 1'b1;    // [RULE_07]
                    end
                    if ((ev_pfin || ev_efin) && here_op && vpp_low) begin
                        part_sts_ff[p][`SR_VLOW] <= 1'b1;    // [RULE_07]
                    end
                    if (ev_pfin && here_op && program_fault) begin
                        part_sts_ff[p][`SR_PFAIL] <= 1'b1;   // [RULE_06]
                    end
                    if (ev_efin && here_op && erase_fault) begin
                        part_sts_ff[p][`SR_EFAIL] <= 1'b1;   // [RULE_04]
                    end
                    if (suspend_req && here_op) begin
                        part_sts_ff[p][`SR_PSUSP] <= op_ff == OP_PROG;   // [RULE_08]
                        part_sts_ff[p][`SR_ESUSP] <= op_ff == OP_ERASE;  // [RULE_03]
                    end
                    if (resume_req && here_op) begin
                        part_sts_ff[p][`SR_PSUSP] <= 1'b0;   // [RULE_14]
                        part_sts_ff[p][`SR_ESUSP] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // per-partition read modes
    // ---------------------------------------------------------------
    generate
        for (genvar p = 0; p < `NUM_PART; p++) begin : g_mode
            always_ff @(posedge clk) begin
                if (dev_rst) begin
                    mode_ff[p] <= MODE_ARRAY;
                end else if (wr_cmd && wr_part == p) begin
                    if (start_any || seq_error) begin
                        mode_ff[p] <= MODE_STATUS;           // [RULE_25]
                    end else if (seq_ff == SEQ_IDLE) begin
                        unique case (cmd)
                            `CMD_READ_ARRAY: mode_ff[p] <= MODE_ARRAY;    // [RULE_20]
                            `CMD_READ_STATUS: mode_ff[p] <= MODE_STATUS;
                            `CMD_READ_ID: mode_ff[p] <= MODE_ID;
                            `CMD_READ_QUERY: mode_ff[p] <= MODE_QUERY;
                            default: mode_ff[p] <= mode_ff[p];            // [RULE_21]
                        endcase
                    end
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // read data path
    // ---------------------------------------------------------------
    // status is frozen between enable edges; other modes follow the address
    always_ff @(posedge clk) begin
        if (dev_rst) begin
            dq_out <= '0;
        end else begin
            unique case (mode_ff[wr_part])
                MODE_ARRAY: dq_out <= arr.rd_data;  // undefined in every partition while a program pulse runs, and in its own partition while it erases
                MODE_STATUS: begin
                    if (rd_latch) begin
                        dq_out <= {8'h00, status_byte(wr_part)};   // [RULE_23] [RULE_21]
                    end
                end
                MODE_ID: begin
                    if (addr[`OFS_W-1:0] == `ID_OFS_MFR) begin
                        dq_out <= MFR_CODE;
                    end else if (addr[`OFS_W-1:0] == `ID_OFS_DEV) begin
                        dq_out <= DEV_CODE;
                    end else if (addr[`OFS_W-1:0] == `ID_OFS_LOCK) begin
                        dq_out <= {15'h0000, locked_blocks[wr_part]};
                    end else begin
                        dq_out <= '0;
                    end
                end
                MODE_QUERY: dq_out <= '0;  // query table not held here
            endcase
        end
    end

    assign dq_oe = !ce_n && !oe_n && we_n;
    // a deselected chip stays awake until the operation finishes or is suspended
    assign standby = ce_n && !busy;                          // [RULE_22]
endmodule // flash_program_status_tracking
`default_nettype wire

// >>> rtl/flash_consts.svh
// constants for the flash program and status tracking block
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH

// ---------------------------------------------------------------
// array geometry
// ---------------------------------------------------------------
`define WORD_W 16
`define ADDR_W 6
`define PART_W 2
`define NUM_PART 4
`define OFS_W 4
`define ERASED_WORD 16'hffff
`define LAST_OFS 4'hf

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define CMD_READ_ARRAY 8'hff
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_ID 8'h90
`define CMD_READ_QUERY 8'h98
`define CMD_PROG_SETUP 8'h40
`define CMD_PROG_SETUP_ALT 8'h10
`define CMD_ERASE_SETUP 8'h20
`define CMD_STREAM_SETUP 8'h30
`define CMD_CONFIRM 8'hd0
`define CMD_SUSPEND 8'hb0

// ---------------------------------------------------------------
// status bit positions
// ---------------------------------------------------------------
`define SR_BUSY 7
`define SR_ESUSP 6
`define SR_EFAIL 5
`define SR_PFAIL 4
`define SR_VLOW 3
`define SR_PSUSP 2
`define SR_LOCK 1
`define SR_PART 0
`define SR_CLEAR 6'h00

// ---------------------------------------------------------------
// identifier offsets and timing
// ---------------------------------------------------------------
`define ID_OFS_MFR 4'h0
`define ID_OFS_DEV 4'h1
`define ID_OFS_LOCK 4'h2
`define CLK_PERIOD_NS 10
`define PROG_TIME_NS 100
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> rtl/flash_pkg.sv
// types shared by the flash status tracking modules
package flash_pkg;
    typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_ID, MODE_QUERY} read_mode_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_PROG, SEQ_ERASE, SEQ_STREAM} seq_t;
    typedef enum logic [2:0] {
        OP_IDLE, OP_PROG, OP_ERASE, OP_STREAM_WAIT, OP_STREAM_PULSE, OP_PSUSP, OP_ESUSP
    } op_t;
endpackage

// >>> rtl/array_if.sv
// port bundle between the controller and the cell array
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"
interface array_if;
    logic wr_en;
    logic [`ADDR_W-1:0] wr_addr;
    logic [`WORD_W-1:0] wr_data;
    logic [`ADDR_W-1:0] rd_addr;
    logic [`WORD_W-1:0] rd_data;
    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> rtl/flash_array.sv
// cell array storage with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"
module flash_array (
    input wire logic clk,
    input wire logic sys_rst,
    array_if.mem mem
);
    logic [`WORD_W-1:0] words [2**`ADDR_W];
    logic [`WORD_W-1:0] rd_data_ff;

    // write port, driven only by the controller's program pulse and erase logic
    always_ff @(posedge clk) begin
        if (mem.wr_en) begin
            words[mem.wr_addr] <= mem.wr_data;
        end
    end

    // read data one cycle after the address
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= words[mem.rd_addr];
        end
    end

    assign mem.rd_data = rd_data_ff;
endmodule // flash_array
`default_nettype wire

// >>> bench/flash_chk.sv
// flash assertion checker
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"
module flash_chk #(parameter int unsigned PROG_CYCLES = 10) (
    input wire logic clk, input wire logic sys_rst, input wire logic rst_n,
    input wire logic ce_n, input wire logic oe_n, input wire logic we_n,
    input wire logic [`ADDR_W-1:0] addr, input wire logic [`WORD_W-1:0] dq_in,
    input wire logic [`WORD_W-1:0] dq_out, input wire logic dq_oe, input wire logic wp_n,
    input wire logic vpp_low, input wire logic standby
);
    logic we_ff, oc_ff, arm_ff;
    logic [3:0] stat_ff;
    logic [7:0] cnt_ff;
    wire logic rs = sys_rst || !rst_n;
    wire logic wr = we_n && !we_ff && !ce_n;
    wire logic rd = !ce_n && !oe_n && we_n && oc_ff;
    wire logic srd = rd && stat_ff[addr[5:4]];
    wire logic launch = wr && arm_ff && wp_n && !vpp_low;
    // edge history
    always_ff @(posedge clk) we_ff <= we_n;
    always_ff @(posedge clk) oc_ff <= oe_n | ce_n;
    // armed by a program setup code
    always_ff @(posedge clk) begin
        if (rs) arm_ff <= 1'b0;
        else if (wr) arm_ff <= !arm_ff && dq_in[7:0] inside {`CMD_PROG_SETUP, `CMD_PROG_SETUP_ALT};
    end
    // per partition status mode
    always_ff @(posedge clk) begin
        if (rs) stat_ff <= 4'h0;
        else if (wr) stat_ff[addr[5:4]] <= arm_ff || !(dq_in[7:0] inside {8'hff, 8'h90, 8'h98});
    end
    // a later write may suspend
    always_ff @(posedge clk) begin
        if (rs || (wr && !launch)) cnt_ff <= 8'h00;
        else if (launch) cnt_ff <= 8'(PROG_CYCLES - 1);
        else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rs);
    AST_OE: assert property (dq_oe == (!ce_n && !oe_n && we_n)) else $error("bad enable");
    AST_STBY_CE: assert property (!ce_n |-> !standby) else $error("standby while selected");
    AST_PROG_BUSY: assert property (cnt_ff != 8'h00 |-> !standby) else $error("early idle");
    AST_RST_OUT: assert property (disable iff (1'b0) rs |=> dq_out == 16'h0000)
        else $error("no clear");
    AST_RST_IDLE: assert property (disable iff (1'b0) rs |=> standby == ce_n)
        else $error("busy");
    AST_UPPER: assert property (srd |=> ##1 dq_out[15:8] == 8'h00)
        else $error("upper byte set");
    AST_PAIR: assert property (srd |=> ##1 !(dq_out[7] && dq_out[0]))
        else $error("both ready bits");
    AST_FREEZE: assert property (srd ##1 (!ce_n && !oe_n) [*3] |-> $stable(dq_out))
        else $error("status moved");
    cover property (launch);
    cover property (srd);
    cover property (wr && dq_in[7:0] == `CMD_SUSPEND);
endmodule // flash_chk
bind flash_program_status_tracking flash_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_i (.clk,
    .sys_rst, .rst_n, .ce_n, .oe_n, .we_n, .addr, .dq_in, .dq_out, .dq_oe, .wp_n, .vpp_low,
    .standby);
`default_nettype wire

// >>> bench/host_model.sv
// host bus model
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"
module host_model (
    input wire logic clk, input wire logic [`WORD_W-1:0] dq_out, output logic ce_n,
    output logic oe_n, output logic we_n, output logic [`ADDR_W-1:0] addr,
    output logic [`WORD_W-1:0] dq_in
);
    initial begin
        {ce_n, oe_n, we_n, addr, dq_in} = {3'b111, 22'h0};
    end
    // held until taken at we_n rise
    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`WORD_W-1:0] v);
        @(posedge clk);
        {ce_n, we_n, addr, dq_in} <= {2'b00, a, v};
        @(posedge clk);
        we_n <= 1'b1;
        @(posedge clk);
        ce_n <= 1'b1;
        dq_in <= ~v; // no stale data
    endtask
    // covers array latency
    task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`WORD_W-1:0] v);
        @(posedge clk);
        {ce_n, oe_n, addr} <= {2'b00, a};
        repeat (4) @(posedge clk);
        v = dq_out;
        {ce_n, oe_n} <= 2'b11;
    endtask
endmodule // host_model
`default_nettype wire

// >>> bench/flash_program_status_tracking_test.sv
// self-checking flash bench
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"
module flash_program_status_tracking_test;
    logic clk = 1'b0, sys_rst = 1'b1, rst_n = 1'b1, wp_n = 1'b1, vpp_low = 1'b0;
    logic program_fault = 1'b0, erase_fault = 1'b0, ce_n, oe_n, we_n, dq_oe, standby;
    logic [3:0] locked_blocks = 4'h8;
    logic [`ADDR_W-1:0] addr;
    logic [`WORD_W-1:0] dq_in, dq_out, d, r, w;
    int err_total = 0, n_compared = 0;
    // setup, data, {wp_n, vpp, faults}, error bits
    logic [27:0] errs [5] = '{28'h40_55_0_02, 28'h40_55_c_08, 28'h40_55_a_10, 28'h20_d0_9_20,
        28'h20_77_8_30};
    always #5 clk = ~clk;
    host_model host (.clk, .dq_out, .ce_n, .oe_n, .we_n, .addr, .dq_in);
    flash_program_status_tracking #(.PROG_CYCLES(20)) DUT (.clk, .sys_rst, .rst_n, .ce_n,
        .oe_n, .we_n, .addr, .dq_in, .dq_out, .dq_oe, .wp_n, .vpp_low, .locked_blocks,
        .program_fault, .erase_fault, .standby);
    function automatic logic [15:0] exp_stat(input logic [7:0] e);
        return {8'h00, 8'h80 | e};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compared=%0d errors=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // bounded poll, low bits ignored while busy
    task automatic poll(input logic [5:0] a);
        for (int i = 0; i < 100 && !d[7]; i++) host.rd(a, d);
    endtask
    initial begin
        void'($urandom(32'haf33aa2d));
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        host.wr(6'h00, 16'h0070);
        host.rd(6'h00, d); chk(d, exp_stat(8'h00));
        host.wr(6'h13, 16'h0020); host.wr(6'h13, 16'h00d0); d = 0; poll(6'h13);
        chk(d, exp_stat(8'h00));
        w = 16'hffff;
        for (int i = 0; i < 2; i++) begin
            r = 16'($urandom);
            w = w & r;
            host.wr(6'h15, i ? 16'h0010 : 16'h0040); host.wr(6'h15, r);
            host.rd(6'h15, d); chk(d & 16'h0081, 16'h0000);
            host.wr(6'h25, 16'h0070); host.rd(6'h25, d); chk(d & 16'h0081, 16'h0001);
            d = 0; poll(6'h15);
            host.wr(6'h15, 16'h00ff); host.rd(6'h15, d); chk(d, w);
        end
        foreach (errs[i]) begin
            {wp_n, vpp_low, program_fault, erase_fault} <= errs[i][11:8];
            host.wr(6'h31, {8'h00, errs[i][27:20]}); host.wr(6'h31, {8'h00, errs[i][19:12]});
            d = 0; poll(6'h31); chk(d, exp_stat(errs[i][7:0]));
            {wp_n, vpp_low, program_fault, erase_fault} <= 4'h8;
            host.rd(6'h31, d); chk(d, exp_stat(errs[i][7:0]));
            host.wr(6'h31, 16'h0050); host.rd(6'h31, d); chk(d, exp_stat(8'h00));
        end
        for (int i = 0; i < 2; i++) begin
            host.wr(6'h17, i ? 16'h0020 : 16'h0040); host.wr(6'h17, i ? 16'h00d0 : 16'($urandom));
            host.wr(6'h17, 16'h00b0); host.rd(6'h17, d); chk(d, exp_stat(i ? 8'h40 : 8'h04));
            host.wr(6'h17, 16'h00d0); d = 0; poll(6'h17); chk(d, exp_stat(8'h00));
        end
        wp_n <= 1'b0; host.wr(6'h31, 16'h0040); host.wr(6'h31, 16'h0055);
        rst_n <= 1'b0; @(posedge clk); rst_n <= 1'b1; wp_n <= 1'b1;
        host.wr(6'h31, 16'h0070); host.rd(6'h31, d); chk(d, exp_stat(8'h00));
        host.wr(6'h32, 16'h0090); host.rd(6'h32, d); chk(d, 16'h0001);
        final_report();
    end
    // hang guard
    initial begin
        #200000;
        err_total++;
        final_report();
    end
endmodule // flash_program_status_tracking_test
`default_nettype wire
